// >>> verilog/bsc_tap.sv
// Boundary scan test access port with inner chip TAP pass-through
`timescale 1ns/100ps
// Functional notes
// - One standard test access port gives boundary scan of the I/O pins.
// - Four-bit instruction register and 32-bit data register, shifted serially.
// - A pass-through path reaches an inner chip-level TAP for tile debug.
// - Test reset low holds all test logic in reset.
// - Identity read selects 32-bit identity: version, part, maker fields.
// - User-code read selects 32-bit usercode: user id, unused, die revision.
// - User id comes from security bits 22 to 31; zero when unprogrammed.
// - Security disable bit 0 blocks tile access through the port.
module bsc_tap
  import bsc_pkg::*;
#(
  parameter logic [9:0] DIE_REV = 10'h000
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_tck,
  input  wire logic        i_trst_n,
  input  wire logic        i_tms,
  input  wire logic        i_tdi,
  output logic             o_tdo,
  output logic             o_tdo_oe,
  input  wire logic [31:0] i_security,
  input  wire logic [31:0] i_bscan_in,
  output logic [31:0]      o_bscan_out,
  output logic             o_extest,
  output logic             o_inner_tms,
  output logic             o_inner_tdi,
  output logic             o_inner_trst_n,
  input  wire logic        i_inner_tdo,
  output logic             o_access_blocked
);
  // ----------------------------------------------------------------
  // Security word crossing into the test clock domain
  // ----------------------------------------------------------------
  logic [31:0] sec_q;
  logic [31:0] sec_meta;
  logic [31:0] sec_sync;
  // Registered in the system domain so the level is quasi-static
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sec_q <= 32'h00000000;
    end else begin
      sec_q <= i_security;
    end
  end
  // Two flops; security bits change only at power-up so no gray needed
  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      sec_meta <= 32'h00000000;
      sec_sync <= 32'h00000000;
    end else begin
      sec_meta <= sec_q;
      sec_sync <= sec_meta;
    end
  end
  logic jtag_disabled;
  assign jtag_disabled = sec_sync[SEC_JTAG_DIS];
  // ----------------------------------------------------------------
  // TAP controller
  // ----------------------------------------------------------------
  bsc_state_t state;
  bsc_state_t next_state;
  // Standard sixteen-state walk driven by TMS
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RESET:  next_state = i_tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_state = i_tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = i_tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = i_tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = i_tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_state = i_tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_state = i_tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = i_tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = i_tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: next_state = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = i_tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = i_tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_state = i_tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_state = i_tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = i_tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end
  // Test reset pin is asynchronous by the standard
  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end
  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [IR_W-1:0] ir_shift;
  logic [IR_W-1:0] ir;
  logic [IR_W-1:0] next_ir_shift;
  logic [IR_W-1:0] next_ir;
  // Capture, shift LSB first, update; reset loads identity read
  always_comb begin
    next_ir_shift = ir_shift;
    next_ir       = ir;
    if (state == ST_CAP_IR) begin
      next_ir_shift = IR_CAPTURE;
    end else if (state == ST_SH_IR) begin
      next_ir_shift = {i_tdi, ir_shift[IR_W-1:1]};
    end
    if (state == ST_UPD_IR) begin
      next_ir = ir_shift;
    end else if (state == ST_RESET) begin
      next_ir = INS_IDREAD;
    end
  end
  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      ir_shift <= IR_CAPTURE;
      ir       <= INS_IDREAD;
    end else begin
      ir_shift <= next_ir_shift;
      ir       <= next_ir;
    end
  end
  // ----------------------------------------------------------------
  // Data register path
  // ----------------------------------------------------------------
  logic sel_id;
  logic sel_uc;
  logic sel_bs;
  logic sel_inner;
  logic sel_byp;
  assign sel_id    = (ir == INS_IDREAD);
  assign sel_uc    = (ir == INS_USERRD);
  assign sel_bs    = (ir == INS_EXTEST) || (ir == INS_SAMPLE);
  assign sel_inner = (ir == INS_INNER) && !jtag_disabled;
  // Unknown codes, all ones and a blocked inner path fall to bypass
  assign sel_byp   = !(sel_id || sel_uc || sel_bs || sel_inner);
  logic [31:0] id_word;
  logic [31:0] uc_word;
  assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  // Unprogrammed fuses read zero, so the field reads zero
  assign uc_word = {sec_sync[31:SEC_USER_LO], 12'h000, DIE_REV};
  logic [DR_W-1:0] dr_shift;
  logic [DR_W-1:0] next_dr_shift;
  logic [DR_W-1:0] bs_upd;
  logic [DR_W-1:0] next_bs_upd;
  logic            byp;
  logic            next_byp;
  // One shift register serves every 32-bit data register
  always_comb begin
    next_dr_shift = dr_shift;
    next_bs_upd   = bs_upd;
    next_byp      = byp;
    if (state == ST_CAP_DR) begin
      next_byp = 1'b0;
      if (sel_id) begin
        next_dr_shift = id_word;
      end else if (sel_uc) begin
        next_dr_shift = uc_word;
      end else if (sel_bs) begin
        next_dr_shift = i_bscan_in;
      end
    end else if (state == ST_SH_DR) begin
      next_dr_shift = {i_tdi, dr_shift[DR_W-1:1]};
      next_byp      = i_tdi;
    end
    if (state == ST_UPD_DR && sel_bs) begin
      next_bs_upd = dr_shift;
    end
  end
  always_ff @(posedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      dr_shift <= 32'h00000000;
      bs_upd   <= 32'h00000000;
      byp      <= 1'b0;
    end else begin
      dr_shift <= next_dr_shift;
      bs_upd   <= next_bs_upd;
      byp      <= next_byp;
    end
  end
  assign o_bscan_out = bs_upd;
  assign o_extest    = (ir == INS_EXTEST);
  // ----------------------------------------------------------------
  // Inner chip TAP pass-through
  // ----------------------------------------------------------------
  // Inner TAP shares our clock; held in reset while the path is shut
  assign o_inner_tms      = sel_inner ? i_tms : 1'b1;
  assign o_inner_tdi      = i_tdi;
  assign o_inner_trst_n   = i_trst_n && !jtag_disabled;
  assign o_access_blocked = jtag_disabled;
  // ----------------------------------------------------------------
  // Output stage on the falling test clock edge
  // ----------------------------------------------------------------
  logic tdo_bit;
  logic next_tdo;
  logic next_oe;
  always_comb begin
    next_oe = (state == ST_SH_DR) || (state == ST_SH_IR);
    if (state == ST_SH_IR) begin
      tdo_bit = ir_shift[0];
    end else if (sel_inner) begin
      tdo_bit = i_inner_tdo;
    end else if (sel_byp) begin
      tdo_bit = byp;
    end else begin
      tdo_bit = dr_shift[0];
    end
    next_tdo = tdo_bit;
  end
  always_ff @(negedge i_tck or negedge i_trst_n) begin
    if (!i_trst_n) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo    <= next_tdo;
      o_tdo_oe <= next_oe;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_sel_ir_exit;
    state == ST_SEL_IR && i_tms;
  endsequence
  a_reset_entry: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    s_sel_ir_exit |=> state == ST_RESET)
    else $error("select-ir with tms high did not reach reset");
  a_five_ones: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    i_tms [*5] |=> state == ST_RESET)
    else $error("five tms ones did not reset controller");
  a_reset_idread: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    state == ST_RESET |=> ir == INS_IDREAD)
    else $error("reset did not select identity read");
  a_id_capture: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    state == ST_CAP_DR && sel_id |=> dr_shift == id_word)
    else $error("identity word not captured");
  a_uc_capture: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    state == ST_CAP_DR && sel_uc |=>
    dr_shift[31:22] == $past(sec_sync[31:22]))
    else $error("usercode user field not from security bits");
  a_ir_width: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    state == ST_SH_IR |=> ir_shift[IR_W-1] == $past(i_tdi))
    else $error("instruction shift did not take tdi");
  a_byp_route: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    ir == INS_BYPASS |-> sel_byp)
    else $error("all ones did not select bypass");
  a_inner_block: assert property (@(posedge i_tck) disable iff (!i_trst_n)
    jtag_disabled |-> !sel_inner && o_inner_tms && !o_inner_trst_n)
    else $error("inner path open while disabled");
  a_trst_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_trst_n |-> state == ST_RESET && !o_tdo_oe)
    else $error("test logic active during test reset");
endmodule : bsc_tap

// >>> inc/bsc_pkg.sv
// Shared constants for the boundary scan test access port
package bsc_pkg;
  // Instruction and data path widths
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  // Instruction encodings (all ones is bypass)
  localparam logic [3:0] INS_EXTEST  = 4'h0;
  localparam logic [3:0] INS_SAMPLE  = 4'h1;
  localparam logic [3:0] INS_IDREAD  = 4'h2;
  localparam logic [3:0] INS_USERRD  = 4'h3;
  localparam logic [3:0] INS_INNER   = 4'h4;
  localparam logic [3:0] INS_BYPASS  = 4'hf;
  // Capture pattern for the instruction register
  localparam logic [3:0] IR_CAPTURE  = 4'h1;
  // Identification fields: arbitrary neutral values
  localparam logic [3:0]  ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART    = 16'h0123;
  localparam logic [10:0] ID_MAKER   = 11'h0aa;
  // Usercode field layout and security disable bit
  localparam int UC_USER_HI = 31;
  localparam int UC_USER_LO = 22;
  localparam int SEC_USER_LO = 22;
  localparam int SEC_JTAG_DIS = 0;
  localparam logic [21:0] UC_LOW_FIELDS = 22'h000000;
  // TAP controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bsc_state_t;
endpackage : bsc_pkg

// >>> verif/bsc_host_model.sv
// Test host model that drives the scan pins of the test port
`timescale 1ns/100ps
module bsc_host_model #(
  parameter int HALF_NS = 80
) (
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  output logic      o_trst_n
);
  // Clock idles low between frames; test reset held from power-up
  initial begin
    o_tck    = 1'b0;
    o_tms    = 1'b1;
    o_tdi    = 1'b0;
    o_trst_n = 1'b0;
  end
  // One test clock period low, above the 100 ns minimum
  task automatic hold_reset();
    o_trst_n = 1'b0;
    #(2 * HALF_NS);
    o_trst_n = 1'b1;
    #(HALF_NS);
  endtask : hold_reset
  // Pins change after falling edge, data out taken at rising edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #(HALF_NS);
    o_tck = 1'b1;
    tdo   = i_tdo;
    #(HALF_NS);
    o_tck = 1'b0;
  endtask : step
  // Data line toggles when unused, so stale values never look valid
  task automatic nav(input logic tms);
    logic t;
    step(tms, ~o_tdi, t);
  endtask : nav
  // Full scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic t;
    dout = '0;
    nav(1'b1);
    if (ir) begin
      nav(1'b1);
    end
    nav(1'b0);
    nav(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    nav(1'b1);
    nav(1'b0);
  endtask : scan
endmodule : bsc_host_model

// >>> verif/bsc_tap_tb_top.sv
// Self-checking bench for the boundary scan test access port
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin \
    n_compared++; \
    if ((gt) !== (ex)) begin \
      num_errors++; \
      $display("FAIL %s exp %h got %h", nm, ex, gt); \
    end \
  end
module bsc_tap_tb_top;
  import bsc_pkg::*;
  localparam logic [9:0]  REV  = 10'h1a5;
  localparam logic [31:0] PINS = 32'h5a5a_c3c3;
  localparam logic [31:0] DAT  = 32'h9e37_79b9;
  localparam logic [31:0] SECU = 32'hb2c0_0000;
  localparam logic [31:0] IDW  = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  localparam logic [31:0] BYP  = {DAT[30:0], 1'b0};
  typedef struct packed {
    logic [3:0]  ins;
    logic [31:0] sec;
    logic [31:0] exp;
  } bsc_row_t;
  // Instruction, security word, expected scan-out
  bsc_row_t rows [9] = '{
    '{INS_IDREAD, 32'h0, IDW},
    '{INS_USERRD, 32'h0, {22'h0, REV}},
    '{INS_USERRD, SECU, {SECU[31:22], 12'h0, REV}},
    '{INS_BYPASS, 32'h0, BYP},
    '{4'h9, 32'h0, BYP},
    '{INS_EXTEST, 32'h0, PINS},
    '{INS_SAMPLE, 32'h0, PINS},
    '{INS_INNER, 32'h0, 32'hffff_ffff},
    '{INS_INNER, 32'h1, BYP}};
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [31:0] sec     = 32'h0;
  logic        tck, tms, tdi, trst_n, tdo, tdo_oe, extest;
  logic        in_tms, in_tdi, in_trst_n, blocked;
  logic [31:0] pins_out, got;
  int          num_errors = 0;
  int          n_compared = 0;
  // ----------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  bsc_tap #(.DIE_REV(REV)) i_dut (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_tck(tck), .i_trst_n(trst_n),
    .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_security(sec), .i_bscan_in(PINS), .o_bscan_out(pins_out),
    .o_extest(extest), .o_inner_tms(in_tms), .o_inner_tdi(in_tdi),
    .o_inner_trst_n(in_trst_n), .i_inner_tdo(1'b1),
    .o_access_blocked(blocked));
  bsc_host_model i_host (.i_tdo(tdo), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi), .o_trst_n(trst_n));
  // Verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // Cuts a hang short, far beyond the normal run
  initial begin
    #400_000;
    num_errors++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Table of instructions, then hand-written cases
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    i_host.hold_reset();
    `CHK("oe idle", 1'b0, tdo_oe)
    i_host.nav(1'b0); // Scans start from idle, not from reset
    for (int r = 0; r < 9; r++) begin
      @(posedge sys_clk);
      sec <= rows[r].sec; // Settles during the IR scan below
      i_host.scan(1'b1, IR_W, {28'h0, rows[r].ins}, got);
      `CHK("ir capture", IR_CAPTURE, got[3:0])
      i_host.scan(1'b0, DR_W, DAT, got);
      `CHK("dr scan", rows[r].exp, got)
      `CHK("extest", rows[r].ins == INS_EXTEST, extest)
      if (rows[r].ins <= INS_SAMPLE) begin
        `CHK("pins out", DAT, pins_out)
      end
      if (rows[r].ins == INS_INNER) begin
        `CHK("blocked", rows[r].sec[0], blocked)
        `CHK("inner rst", ~rows[r].sec[0], in_trst_n)
        `CHK("inner tdi", tdi, in_tdi)
        if (!rows[r].sec[0]) begin
          `CHK("inner tms", tms, in_tms)
        end
      end
    end
    // Five TMS ones from idle fall back to the identity read
    i_host.scan(1'b1, IR_W, {28'h0, INS_BYPASS}, got);
    repeat (5) i_host.nav(1'b1);
    i_host.nav(1'b0);
    i_host.scan(1'b0, DR_W, DAT, got);
    `CHK("tms reset", IDW, got)
    // Test reset in mid-run drops the loaded instruction
    i_host.scan(1'b1, IR_W, {28'h0, INS_BYPASS}, got);
    i_host.hold_reset();
    `CHK("oe reset", 1'b0, tdo_oe)
    i_host.nav(1'b0);
    i_host.scan(1'b0, DR_W, DAT, got);
    `CHK("trst reset", IDW, got)
    // Select-IR with TMS high falls to reset and reloads identity read
    i_host.scan(1'b1, IR_W, {28'h0, INS_BYPASS}, got);
    repeat (3) i_host.nav(1'b1);
    i_host.nav(1'b0);
    i_host.scan(1'b0, DR_W, DAT, got);
    `CHK("sel-ir reset", IDW, got)
    // Enable stands while shifting; step off the falling edge first
    i_host.nav(1'b1);
    i_host.nav(1'b0);
    i_host.nav(1'b0);
    #1;
    `CHK("oe shift", 1'b1, tdo_oe)
    `CHK("tdo first", IDW[0], tdo)
    i_host.nav(1'b1);
    i_host.nav(1'b1);
    i_host.nav(1'b0);
    conclude();
  end
endmodule : bsc_tap_tb_top
